// ==== sirq_consts.svh ====
// Offsets, field positions, reset values and timing counts of the serial interrupt host.
`ifndef SIRQ_CONSTS_SVH
`define SIRQ_CONSTS_SVH
`define SIRQ_CTRL_OFFSET   8'h64
`define SIRQ_CTRL_RESET    8'h00
`define SIRQ_CTRL_EN_BIT   7
`define SIRQ_CTRL_CONT_BIT 6
`define SIRQ_CTRL_WID_HI   1
`define SIRQ_CTRL_WID_LO   0
`define SIRQ_NUM_FRAMES    21
`define SIRQ_START_W0      3'h4
`define SIRQ_START_W1      3'h6
`define SIRQ_START_W2      3'h0
`define SIRQ_STOP_QUIET    3'h2
`define SIRQ_STOP_CONT     3'h3
`define SIRQ_FR_SMI        2
`define SIRQ_FR_IRQ14      14
`define SIRQ_FR_IO_CHANNEL_CHECK_ALT      16
`define SIRQ_FR_PCI_A      17
`define SIRQ_FIFO_DEPTH    8
`endif

// ==== sirq_pkg.sv ====
// Types shared by the serial interrupt host.
package sirq_pkg;
   typedef enum logic [2:0] {
      SIRQ_IDLE  = 3'b000,
      SIRQ_START = 3'b001,
      SIRQ_REC   = 3'b010,
      SIRQ_TA    = 3'b011,
      SIRQ_DATA  = 3'b100,
      SIRQ_STOP  = 3'b101,
      SIRQ_SREC  = 3'b110,
      SIRQ_STA   = 3'b111
   } sirq_state_e;
   typedef logic [20:0] sirq_word_t;
endpackage

// ==== sirq_host.sv ====
// Serial interrupt host engine with its sampled-frame buffer.
`timescale 1ns/10ps
`include "sirq_consts.svh"

// --------------------------------------------------------------------------
// Frame buffer
// --------------------------------------------------------------------------
module sirq_fifo #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module sirq_host #(
   parameter int FIFO_DEPTH = `SIRQ_FIFO_DEPTH
) (
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 cfg_wr,
   input  wire logic [7:0]           cfg_addr,
   input  wire logic [7:0]           cfg_wdata,
   output logic      [7:0]           cfg_rdata,
   input  wire logic                 shared_irq_line_in,
   output logic                      shared_irq_line_out,
   output logic                      shared_irq_line_oe,
   input  wire logic                 pci_irq_line_a_n,
   input  wire logic                 pci_irq_line_b_n,
   input  wire logic                 pci_irq_line_c_n,
   input  wire logic                 pci_irq_line_d_n,
   input  wire logic                 timer_heartbeat_irq,
   input  wire logic                 rtc_irq,
   input  wire logic                 fpu_error_irq,
   input  wire logic [1:0]           native_ide_irq,
   input  wire logic                 io_channel_check_alt_n,
   input  wire logic                 smi_status_clr,
   output logic      [15:0]          isa_irq,
   output logic      [3:0]           pci_irq_req_n,
   output logic      [1:0]           bm_ide_irq,
   output logic                      system_mgmt_request,
   output logic                      serial_smi_status_bit,
   output logic                      io_channel_check,
   output logic                      word_valid,
   input  wire logic                 word_ready,
   output sirq_pkg::sirq_word_t      word_data
);
   import sirq_pkg::*;

   sirq_state_e state;
   logic [7:0]  serial_irq_control;
   logic        en_q;
   logic        quiet_mode;
   logic [2:0]  lcnt;
   logic [1:0]  ph;
   logic [4:0]  fidx;
   sirq_word_t  frames;
   logic        push;
   logic        buf_ready;
   logic [2:0]  start_w;
   logic [2:0]  stop_w;
   logic        gap_done;
   logic        enabled;

   // -----------------------------------------------------------------------
   // Control register
   // -----------------------------------------------------------------------
   assign enabled = serial_irq_control[`SIRQ_CTRL_EN_BIT];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         serial_irq_control <= `SIRQ_CTRL_RESET;
         cfg_rdata          <= 8'h00;
      end else begin
         if (cfg_wr && (cfg_addr == `SIRQ_CTRL_OFFSET)) begin
            serial_irq_control <= cfg_wdata;
         end
         if (cfg_addr == `SIRQ_CTRL_OFFSET) begin
            cfg_rdata <= serial_irq_control;
         end else begin
            cfg_rdata <= 8'h00;
         end
      end
   end

   // Codes 2'b00 and 2'b11 both give the shortest frame, four clocks; a width of zero wraps to eight clocks.
   always_comb begin
      case (serial_irq_control[`SIRQ_CTRL_WID_HI:`SIRQ_CTRL_WID_LO])
         2'b01:   start_w = `SIRQ_START_W1;
         2'b10:   start_w = `SIRQ_START_W2;
         default: start_w = `SIRQ_START_W0;
      endcase
   end

   // Bit 6 picks the stop width and with it the mode of the next cycle.
   assign stop_w = serial_irq_control[`SIRQ_CTRL_CONT_BIT] ? `SIRQ_STOP_CONT
                                                           : `SIRQ_STOP_QUIET;

   // -----------------------------------------------------------------------
   // Frame sequencer and line drive
   // -----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state               <= SIRQ_IDLE;
         shared_irq_line_out <= 1'b1;
         shared_irq_line_oe  <= 1'b0;
         lcnt                <= 3'h0;
         ph                  <= 2'h0;
         fidx                <= 5'h00;
         frames              <= '1;
         quiet_mode          <= 1'b0;
         en_q                <= 1'b0;
         gap_done            <= 1'b0;
      end else begin
         en_q <= enabled;
         case (state)
            SIRQ_IDLE: begin
               shared_irq_line_oe <= 1'b0;
               gap_done           <= 1'b1;
               if (enabled && en_q && buf_ready) begin
                  if (!quiet_mode && gap_done) begin
                     state               <= SIRQ_START;
                     lcnt                <= start_w - 3'h1;
                     shared_irq_line_out <= 1'b0;
                     shared_irq_line_oe  <= 1'b1;
                  end else if (quiet_mode && !shared_irq_line_in) begin
                     state               <= SIRQ_START;
                     lcnt                <= start_w - 3'h2;
                     shared_irq_line_out <= 1'b0;
                     shared_irq_line_oe  <= 1'b1;
                  end
               end
            end
            SIRQ_START: begin
               if (lcnt == 3'h0) begin
                  state               <= SIRQ_REC;
                  shared_irq_line_out <= 1'b1;
               end else begin
                  lcnt <= lcnt - 3'h1;
               end
            end
            SIRQ_REC: begin
               state              <= SIRQ_TA;
               shared_irq_line_oe <= 1'b0;
               ph                 <= 2'h0;
               fidx               <= 5'h00;
            end
            SIRQ_TA: begin
               state <= SIRQ_DATA;
            end
            SIRQ_DATA: begin
               if (ph == 2'h0) begin
                  frames[fidx] <= shared_irq_line_in;
               end
               if (ph == 2'h2) begin
                  ph <= 2'h0;
                  if (fidx == 5'(`SIRQ_NUM_FRAMES - 1)) begin
                     state               <= SIRQ_STOP;
                     lcnt                <= stop_w - 3'h1;
                     shared_irq_line_out <= 1'b0;
                     shared_irq_line_oe  <= 1'b1;
                  end else begin
                     fidx <= fidx + 5'h01;
                  end
               end else begin
                  ph <= ph + 2'h1;
               end
            end
            SIRQ_STOP: begin
               if (lcnt == 3'h0) begin
                  state               <= SIRQ_SREC;
                  shared_irq_line_out <= 1'b1;
                  quiet_mode          <= (stop_w == `SIRQ_STOP_QUIET);
               end else begin
                  lcnt <= lcnt - 3'h1;
               end
            end
            SIRQ_SREC: begin
               state              <= SIRQ_STA;
               shared_irq_line_oe <= 1'b0;
            end
            default: begin
               state    <= SIRQ_IDLE;
               gap_done <= 1'b0;
            end
         endcase
         if (enabled && !en_q) begin
            quiet_mode <= 1'b0;
         end
      end
   end

   // A cycle's word is pushed as the stop frame begins.
   assign push = (state == SIRQ_DATA) && (ph == 2'h2)
              && (fidx == 5'(`SIRQ_NUM_FRAMES - 1));

   // -----------------------------------------------------------------------
   // Slot decode
   // -----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         isa_irq             <= 16'h0000;
         pci_irq_req_n       <= 4'hf;
         bm_ide_irq          <= 2'h0;
         system_mgmt_request <= 1'b0;
         io_channel_check    <= 1'b0;
      end else begin
         isa_irq[0]          <= timer_heartbeat_irq;
         isa_irq[8]          <= rtc_irq;
         isa_irq[13]         <= fpu_error_irq;
         isa_irq[2]          <= 1'b0;
         bm_ide_irq          <= native_ide_irq;
         system_mgmt_request <= push && !frames[`SIRQ_FR_SMI];
         io_channel_check    <= !io_channel_check_alt_n
                             || (push && !frames[`SIRQ_FR_IO_CHANNEL_CHECK_ALT]);
         pci_irq_req_n <= {pci_irq_line_d_n, pci_irq_line_c_n,
                           pci_irq_line_b_n, pci_irq_line_a_n}
                        & frames[`SIRQ_FR_PCI_A+3:`SIRQ_FR_PCI_A];
         if (push) begin
            isa_irq[1]    <= !frames[1];
            isa_irq[7:3]  <= ~frames[7:3];
            isa_irq[12:9] <= ~frames[12:9];
         end
         isa_irq[15:14] <= ~frames[`SIRQ_FR_IRQ14+1:`SIRQ_FR_IRQ14]
                         | native_ide_irq;
      end
   end

   // Set wins over a clear arriving in the same cycle.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         serial_smi_status_bit <= 1'b0;
      end else if (push && !frames[`SIRQ_FR_SMI]) begin
         serial_smi_status_bit <= 1'b1;
      end else if (smi_status_clr) begin
         serial_smi_status_bit <= 1'b0;
      end
   end

   // -----------------------------------------------------------------------
   // Buffer; a full buffer holds off the next start frame.
   // -----------------------------------------------------------------------
   sirq_fifo #(
      .WIDTH ($bits(sirq_word_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_valid  (push),
      .in_ready  (buf_ready),
      .in_data   (frames),
      .out_valid (word_valid),
      .out_ready (word_ready),
      .out_data  (word_data)
   );

   // -----------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------
   sequence s_low_end;
      shared_irq_line_oe && !shared_irq_line_out ##1 shared_irq_line_out;
   endsequence

   a_drive_high_release: assert property (@(posedge clk) disable iff (sys_rst)
      s_low_end |-> shared_irq_line_oe ##1 !shared_irq_line_oe)
      else $error("Low drive not followed by high then release.");

   a_first_continuous: assert property (@(posedge clk) disable iff (sys_rst)
      (enabled && !en_q) |=> !quiet_mode)
      else $error("Enable did not select continuous mode.");

   a_start_width_four: assert property (@(posedge clk) disable iff (sys_rst)
      (state == SIRQ_IDLE && !quiet_mode && serial_irq_control[1:0] == 2'b00
       ##1 state == SIRQ_START) |-> (state == SIRQ_START)[*4] ##1 state == SIRQ_REC)
      else $error("Continuous start frame not four clocks.");

   a_quiet_width: assert property (@(posedge clk) disable iff (sys_rst)
      (state == SIRQ_IDLE && quiet_mode && serial_irq_control[1:0] == 2'b00
       ##1 state == SIRQ_START) |-> (state == SIRQ_START)[*3] ##1 state == SIRQ_REC)
      else $error("Quiet start frame not one clock shorter.");

   a_frame_one_time: assert property (@(posedge clk) disable iff (sys_rst)
      (state == SIRQ_REC) |-> ##2 (state == SIRQ_DATA && ph == 2'h0 && fidx == 5'h00))
      else $error("Frame one not sampled two clocks after start.");

   a_last_frame_time: assert property (@(posedge clk) disable iff (sys_rst)
      (state == SIRQ_REC) |-> ##62 (state == SIRQ_DATA && ph == 2'h0 && fidx == 5'h14))
      else $error("Frame 21 not sampled 62 clocks after start.");

   a_stop_width: assert property (@(posedge clk) disable iff (sys_rst)
      push && stop_w == `SIRQ_STOP_CONT |=> (state == SIRQ_STOP)[*3] ##1 state == SIRQ_SREC)
      else $error("Continuous stop frame not three clocks.");

   a_next_mode: assert property (@(posedge clk) disable iff (sys_rst)
      (state == SIRQ_SREC) |-> quiet_mode == (stop_w == `SIRQ_STOP_QUIET))
      else $error("Stop width did not select next mode.");

   a_idle_gap: assert property (@(posedge clk) disable iff (sys_rst)
      (state == SIRQ_STA && !quiet_mode) |=> state == SIRQ_IDLE ##1 state == SIRQ_IDLE)
      else $error("No idle clock before next start.");

   a_smi_from_frame: assert property (@(posedge clk) disable iff (sys_rst)
      (push && !frames[`SIRQ_FR_SMI]) |=> system_mgmt_request && serial_smi_status_bit)
      else $error("Frame 3 low did not raise management request.");

   a_pci_and: assert property (@(posedge clk) disable iff (sys_rst)
      !pci_irq_line_a_n |=> !pci_irq_req_n[0])
      else $error("Dedicated PCI input did not assert request.");
endmodule

// ==== sirq_periph_model.sv ====
// Behavioural serial interrupt peripheral sharing the interrupt line with the host.
`timescale 1ns/10ps
module sirq_periph_model (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        line,
   input  wire logic        start_req,
   input  wire logic [20:0] req,
   output logic             drv_oe,
   output logic             drv_out
);
   logic [1:0] ph;
   logic [6:0] cnt;
   logic [6:0] nc;
   logic       prev;
   logic       drove;

   assign nc = cnt + 7'h01;

   // -----------------------------------------------------------------------
   // Frame tracking and line drive
   // -----------------------------------------------------------------------
   // Phase 0 waits for a start, 1 for the rise that ends it, 2 counts frames,
   // 3 waits for the rise that ends the stop frame.
   always_ff @(posedge clk) begin
      prev <= line;
      drv_oe <= 1'b0;
      drv_out <= 1'b1;
      if (sys_rst) begin
         ph <= 2'h0;
         cnt <= 7'h00;
         drove <= 1'b0;
      end else begin
         case (ph)
            2'h0: if (start_req) begin
               drv_oe <= 1'b1;
               drv_out <= 1'b0;
               ph <= 2'h1;
            end else if (!line) begin
               ph <= 2'h1;
            end
            2'h1: if (line && !prev) begin
               ph <= 2'h2;
               cnt <= 7'h01;
            end
            2'h2: begin
               cnt <= nc;
               if (nc <= 7'h3e && (nc - 7'h02) % 3 == 0 && req[(nc - 7'h02) / 3]) begin
                  drv_oe <= 1'b1;
                  drv_out <= 1'b0;
                  drove <= 1'b1;
               end else if (drove) begin
                  drv_oe <= 1'b1;
                  drove <= 1'b0;
               end
               if (nc == 7'h40) begin
                  ph <= 2'h3;
               end
            end
            default: if (line && !prev) begin
               ph <= 2'h0;
            end
         endcase
      end
   end
endmodule

// ==== sirq_host_test.sv ====
// Self-checking testbench of the serial interrupt host.
`timescale 1ns/10ps
`include "sirq_consts.svh"
`define CHK(g, e) chk((g), (e))
module sirq_host_test;
   logic                 clk, sys_rst, cfg_wr, smi_status_clr, word_ready, start_req;
   logic                 timer_heartbeat_irq, rtc_irq, fpu_error_irq, io_channel_check_alt_n;
   logic                 line, host_out, host_oe, per_oe, per_out, word_valid;
   logic                 system_mgmt_request, serial_smi_status_bit, io_channel_check;
   logic [7:0]           cfg_addr, cfg_wdata, cfg_rdata, d;
   logic [3:0]           pci_n, pci_irq_req_n;
   logic [1:0]           native_ide_irq, bm_ide_irq;
   logic [15:0]          isa_irq, e;
   logic [20:0]          req;
   sirq_pkg::sirq_word_t word_data;
   int                   n_errors, n_compared, lo_run, hi_run, hi_keep, n_smi, n_ioc, cycles;
   int                   lows[$], his[$];

   // Pull-up on the shared line; any low drive wins.
   assign line = ((host_oe & ~host_out) | (per_oe & ~per_out)) ? 1'b0 : 1'b1;

   sirq_host #(.FIFO_DEPTH(8)) DUT (.clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .shared_irq_line_in(line), .shared_irq_line_out(host_out), .shared_irq_line_oe(host_oe),
      .pci_irq_line_a_n(pci_n[0]), .pci_irq_line_b_n(pci_n[1]), .pci_irq_line_c_n(pci_n[2]),
      .pci_irq_line_d_n(pci_n[3]), .timer_heartbeat_irq(timer_heartbeat_irq),
      .rtc_irq(rtc_irq), .fpu_error_irq(fpu_error_irq), .native_ide_irq(native_ide_irq),
      .io_channel_check_alt_n(io_channel_check_alt_n), .smi_status_clr(smi_status_clr),
      .isa_irq(isa_irq), .pci_irq_req_n(pci_irq_req_n), .bm_ide_irq(bm_ide_irq),
      .system_mgmt_request(system_mgmt_request), .serial_smi_status_bit(serial_smi_status_bit),
      .io_channel_check(io_channel_check), .word_valid(word_valid), .word_ready(word_ready),
      .word_data(word_data));

   sirq_periph_model PER (.clk(clk), .sys_rst(sys_rst), .line(line), .start_req(start_req),
      .req(req), .drv_oe(per_oe), .drv_out(per_out));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // -----------------------------------------------------------------------
   // Line monitor: low runs of two clocks or more are start and stop frames
   // -----------------------------------------------------------------------
   always @(posedge clk) begin
      cycles++;
      if (!line) begin
         if (lo_run == 0) begin
            hi_keep = hi_run;
         end
         lo_run++;
         hi_run = 0;
      end else begin
         if (lo_run >= 2) begin
            lows.push_back(lo_run);
            his.push_back(hi_keep);
         end
         lo_run = 0;
         hi_run++;
      end
      if (system_mgmt_request === 1'b1) n_smi++;
      if (io_channel_check === 1'b1) n_ioc++;
      if (cycles == 10000) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, cycles, 0);
         finish_test();
      end
   end

   // -----------------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk);
      cfg_addr = a;
      cfg_wdata = v;
      cfg_wr = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk);
      cfg_addr = a;
      @(negedge clk);
      v = cfg_rdata;
   endtask

   // Disables the engine and lets any running cycle finish.
   task automatic park();
      wr(8'h64, 8'h00);
      word_ready = 1'b1;
      repeat (100) @(negedge clk);
      lows.delete();
      his.delete();
   endtask

   task automatic get_word(input logic [20:0] x);
      int t;
      t = 0;
      while (word_valid !== 1'b1 && t < 400) begin
         @(negedge clk);
         t++;
      end
      `CHK(word_data, x);
      word_ready = 1'b1;
      @(negedge clk);
      word_ready = 1'b0;
   endtask

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // -----------------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------------
   initial begin
      {cfg_wr, cfg_addr, cfg_wdata, smi_status_clr, word_ready, start_req} = '0;
      {timer_heartbeat_irq, rtc_irq, fpu_error_irq, native_ide_irq, req} = '0;
      pci_n = 4'hf;
      io_channel_check_alt_n = 1'b1;
      sys_rst = 1'b1;
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      rd(8'h64, d);
      `CHK(d, `SIRQ_CTRL_RESET);
      wr(8'h65, 8'hff);
      rd(8'h65, d);
      `CHK(d, 8'h00);
      rd(8'h64, d);
      `CHK(d, 8'h00);
      wr(8'h64, 8'h43);
      rd(8'h64, d);
      `CHK(d, 8'h43);
      $display("config test done");
      for (int c = 0; c < 4; c++) begin
         park();
         word_ready = 1'b1;
         wr(8'h64, 8'hc0 | 8'(c));
         repeat (170) @(negedge clk);
         `CHK(lows[0], c == 1 ? 6 : (c == 2 ? 8 : 4));
         `CHK(lows[1], 3);
         `CHK(his[2] >= 3, 1);
      end
      $display("start width test done");
      for (int p = 0; p < 2; p++) begin
         park();
         word_ready = 1'b0;
         req = p ? 21'h000000 : 21'h1fffff;
         {timer_heartbeat_irq, rtc_irq, fpu_error_irq} = p ? 3'h7 : 3'h0;
         native_ide_irq = p ? 2'h1 : 2'h0;
         pci_n = p ? 4'ha : 4'hf;
         io_channel_check_alt_n = p ? 1'b0 : 1'b1;
         smi_status_clr = 1'b1;
         @(negedge clk);
         smi_status_clr = 1'b0;
         n_smi = 0;
         n_ioc = 0;
         wr(8'h64, 8'hc0);
         get_word(~req);
         get_word(~req);
         repeat (2) @(negedge clk);
         e = req[15:0];
         e[2] = 1'b0;
         e[0] = timer_heartbeat_irq;
         e[8] = rtc_irq;
         e[13] = fpu_error_irq;
         e[15:14] = req[15:14] | native_ide_irq;
         `CHK(isa_irq, e);
         `CHK(bm_ide_irq, native_ide_irq);
         `CHK(pci_irq_req_n, pci_n & ~req[20:17]);
         `CHK(n_smi != 0, p == 0);
         `CHK(serial_smi_status_bit, p == 0);
         `CHK(n_ioc != 0, 1);
      end
      $display("decode test done");
      park();
      word_ready = 1'b1;
      req = 21'h000004;
      wr(8'h64, 8'h80);
      repeat (400) @(negedge clk);
      `CHK(lows.size(), 2);
      `CHK(lows[1], 2);
      start_req = 1'b1;
      @(negedge clk);
      start_req = 1'b0;
      repeat (100) @(negedge clk);
      `CHK(lows.size(), 4);
      `CHK(lows[2], 4);
      $display("quiet mode test done");
      park();
      word_ready = 1'b0;
      req = 21'h10a841;
      wr(8'h64, 8'hc0);
      repeat (1000) @(negedge clk);
      `CHK(lows.size(), 16);
      wr(8'h64, 8'h00);
      for (int i = 0; i < 8; i++) begin
         get_word(~req);
      end
      repeat (2) @(negedge clk);
      `CHK(word_valid, 1'b0);
      $display("buffer test done");
      finish_test();
   end
endmodule
